// ===== src/hpf_coef_pkg.sv
// Purpose: Shared constants and types for the record-path high-pass coefficient bank
// Assumes: Byte-wide register port, page-one register numbers used as addresses
// Notes: Reset values are the power-on coefficient defaults
package hpf_coef_pkg;

	// ==========================================================
	// Register numbers within page one
	localparam logic [6:0] LEFT_NUM_FIRST_HIGH_OFS = 7'h41;
	localparam logic [6:0] LEFT_NUM_FIRST_LOW_OFS = 7'h42;
	localparam logic [6:0] LEFT_NUM_SECOND_HIGH_OFS = 7'h43;
	localparam logic [6:0] LEFT_NUM_SECOND_LOW_OFS = 7'h44;
	localparam logic [6:0] LEFT_DEN_HIGH_OFS = 7'h45;
	localparam logic [6:0] LEFT_HPF_DENOMINATOR_LOW_OFS = 7'h46;
	localparam logic [6:0] RIGHT_HPF_NUM_FIRST_HIGH_OFS = 7'h47;
	localparam logic [6:0] RIGHT_HPF_NUM_FIRST_LOW_OFS = 7'h48;
	localparam logic [6:0] RIGHT_HPF_NUM_SECOND_HIGH_OFS = 7'h49;
	localparam logic [6:0] RIGHT_HPF_NUM_SECOND_LOW_OFS = 7'h4a;
	localparam logic [6:0] RIGHT_HPF_DENOMINATOR_HIGH_OFS = 7'h4b;
	localparam logic [6:0] RIGHT_HPF_DENOMINATOR_LOW_OFS = 7'h4c;
	localparam logic [6:0] PAGE_ONE_RESERVED_TAIL_OFS = 7'h4d;
	localparam logic [6:0] PAGE_ONE_LAST_OFS = 7'h7f;
	localparam int NUM_COEF_BYTES = 12;

	// ==========================================================
	// Reset defaults, one per byte
	localparam logic [7:0] NUM_FIRST_HIGH_RST = 8'h39;
	localparam logic [7:0] NUM_FIRST_LOW_RST = 8'h55;
	localparam logic [7:0] NUM_SECOND_HIGH_RST = 8'hf3;
	localparam logic [7:0] NUM_SECOND_LOW_RST = 8'h2d;
	localparam logic [7:0] DEN_HIGH_RST = 8'h53;
	localparam logic [7:0] DEN_LOW_RST = 8'h7e;
	localparam logic [7:0] RESERVED_READ_VALUE = 8'h00;

	// ==========================================================
	// Types
	typedef logic signed [15:0] coef_t;

	typedef struct packed {
		coef_t numerator_first_coef;
		coef_t numerator_second_coef;
		coef_t denominator_coef;
	} hpf_coefs_t;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [6:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

endpackage

// ===== src/coef_byte_reg.sv
// Purpose: One byte of coefficient storage with its own reset default
// Assumes: Single clock, asynchronous active-low reset
// Notes: Write enable comes from the decode in the bank
`timescale 1ns/1ps
module coef_byte_reg
#(
	parameter logic [7:0] RESET_VALUE = 8'h00
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Write side
	input wire logic wr_en_in,
	input wire logic [7:0] wdata_in,
	// Stored value
	output logic [7:0] value_out
);

	logic [7:0] value_d;
	logic [7:0] value_q;

	// Hold unless written
	always_comb
	begin
		value_d = value_q;
		if (wr_en_in)
		begin
			value_d = wdata_in;
		end
	end

	// Reset loads the byte default
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			value_q <= RESET_VALUE;
		end
		else
		begin
			value_q <= value_d;
		end
	end

	assign value_out = value_q;

endmodule // coef_byte_reg

// ===== src/adc_highpass_coef_bank.sv
// Purpose: Byte-wide coefficient registers for the left and right record high-pass filters
// Assumes: Register access arrives already decoded from the control bus as byte strobes
// Notes: Page selection and filter arithmetic live outside this bank
//
// Overview of operation
// - Each coefficient is an upper byte joined with a lower byte into a signed 16-bit word.
// - The left denominator lower byte at register 70 resets to 0x7e and is read/write.
// - The right first numerator resets to 0x39 upper (71) and 0x55 lower (72), read/write.
// - The right second numerator resets to 0xf3 upper (73) and 0x2d lower (74), read/write.
// - The right denominator resets to 0x53 upper (75) and 0x7e lower (76), read/write.
// - Registers 77 to 127 read as zero and the host never writes them.
// - The left first numerator resets to 0x39 upper (65) and 0x55 lower (66).
// - The left second numerator resets to 0xf3/0x2d (67/68), denominator upper to 0x53 (69).
`timescale 1ns/1ps
module adc_highpass_coef_bank
(
	// Clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RESETN_IN,
	// Register port from the control bus slave
	input wire logic REG_WR_EN_IN,
	input wire logic REG_RD_EN_IN,
	input wire logic [6:0] REG_ADDR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	output logic [7:0] REG_RDATA_OUT,
	output logic REG_HIT_OUT,
	// Coefficients toward the filters
	output hpf_coef_pkg::hpf_coefs_t LEFT_COEFS_OUT,
	output hpf_coef_pkg::hpf_coefs_t RIGHT_COEFS_OUT
);

	// ==========================================================
	// Request bundle and byte table
	hpf_coef_pkg::reg_req_t req;
	logic [7:0] byte_val [hpf_coef_pkg::NUM_COEF_BYTES];
	logic [hpf_coef_pkg::NUM_COEF_BYTES-1:0] byte_wr;

	assign req.wr_en = REG_WR_EN_IN;
	assign req.rd_en = REG_RD_EN_IN;
	assign req.addr = REG_ADDR_IN;
	assign req.wdata = REG_WDATA_IN;

	// Index of a coefficient byte inside the bank, or -1 when outside it
	function automatic int byte_index(input logic [6:0] addr);
		byte_index = -1;
		if (addr >= hpf_coef_pkg::LEFT_NUM_FIRST_HIGH_OFS &&
			addr < hpf_coef_pkg::PAGE_ONE_RESERVED_TAIL_OFS)
		begin
			byte_index = int'(addr - hpf_coef_pkg::LEFT_NUM_FIRST_HIGH_OFS);
		end
	endfunction

	// Join an upper and a lower byte into one signed coefficient
	function automatic hpf_coef_pkg::coef_t join_coef(input logic [7:0] hi, input logic [7:0] lo);
		join_coef = hpf_coef_pkg::coef_t'({hi, lo});
	endfunction

	// ==========================================================
	// Storage: byte order follows register order, upper byte first
	localparam logic [7:0] RESET_TABLE [hpf_coef_pkg::NUM_COEF_BYTES] = '{
		hpf_coef_pkg::NUM_FIRST_HIGH_RST,
		hpf_coef_pkg::NUM_FIRST_LOW_RST,
		hpf_coef_pkg::NUM_SECOND_HIGH_RST,
		hpf_coef_pkg::NUM_SECOND_LOW_RST,
		hpf_coef_pkg::DEN_HIGH_RST,
		hpf_coef_pkg::DEN_LOW_RST,
		hpf_coef_pkg::NUM_FIRST_HIGH_RST,
		hpf_coef_pkg::NUM_FIRST_LOW_RST,
		hpf_coef_pkg::NUM_SECOND_HIGH_RST,
		hpf_coef_pkg::NUM_SECOND_LOW_RST,
		hpf_coef_pkg::DEN_HIGH_RST,
		hpf_coef_pkg::DEN_LOW_RST
	};

	// Write decode; the reserved tail has no storage, so stray writes there are dropped
	always_comb
	begin
		byte_wr = '0;
		if (req.wr_en && byte_index(req.addr) >= 0)
		begin
			byte_wr[byte_index(req.addr)] = 1'b1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < hpf_coef_pkg::NUM_COEF_BYTES; gi++)
		begin : g_byte
			coef_byte_reg #(
				.RESET_VALUE(RESET_TABLE[gi])
			) u_byte (
				.clk_in(CORE_CLK_IN),
				.rst_n_in(RESETN_IN),
				.wr_en_in(byte_wr[gi]),
				.wdata_in(req.wdata),
				.value_out(byte_val[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Read path, registered so data leaves from flip-flops
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic hit_d;
	logic hit_q;

	// Read mux: coefficient bytes return storage, tail returns zero
	always_comb
	begin
		rdata_d = rdata_q;
		hit_d = 1'b0;
		if (req.rd_en)
		begin
			hit_d = req.addr >= hpf_coef_pkg::LEFT_NUM_FIRST_HIGH_OFS;
			if (byte_index(req.addr) >= 0)
			begin
				rdata_d = byte_val[byte_index(req.addr)];
			end
			else
			begin
				rdata_d = hpf_coef_pkg::RESERVED_READ_VALUE;
			end
		end
	end

	// Read data register
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			rdata_q <= 8'h00;
			hit_q <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			hit_q <= hit_d;
		end
	end

	assign REG_RDATA_OUT = rdata_q;
	assign REG_HIT_OUT = hit_q;

	// ==========================================================
	// Coefficient words to the filters, straight from storage flops
	always_comb
	begin
		LEFT_COEFS_OUT.numerator_first_coef = join_coef(byte_val[0], byte_val[1]);
		LEFT_COEFS_OUT.numerator_second_coef = join_coef(byte_val[2], byte_val[3]);
		LEFT_COEFS_OUT.denominator_coef = join_coef(byte_val[4], byte_val[5]);
		RIGHT_COEFS_OUT.numerator_first_coef = join_coef(byte_val[6], byte_val[7]);
		RIGHT_COEFS_OUT.numerator_second_coef = join_coef(byte_val[8], byte_val[9]);
		RIGHT_COEFS_OUT.denominator_coef = join_coef(byte_val[10], byte_val[11]);
	end

	// ==========================================================
	// Checks
	logic past_valid_q;
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			past_valid_q <= 1'b0;
		end
		else
		begin
			past_valid_q <= 1'b1;
		end
	end

	// Byte that a register number names within the coefficient outputs, upper byte first
	function automatic logic [7:0] pick_byte(input hpf_coef_pkg::hpf_coefs_t l,
		input hpf_coef_pkg::hpf_coefs_t r, input logic [6:0] addr);
		logic [8*hpf_coef_pkg::NUM_COEF_BYTES-1:0] words;
		int k;
		words = {l, r};
		k = byte_index(addr);
		pick_byte = 8'h00;
		if (k >= 0)
		begin
			pick_byte = words[8*hpf_coef_pkg::NUM_COEF_BYTES-1-8*k -: 8];
		end
	endfunction

	reserved_zero_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		REG_RD_EN_IN && REG_ADDR_IN >= hpf_coef_pkg::PAGE_ONE_RESERVED_TAIL_OFS
		|=> REG_RDATA_OUT == 8'h00 && REG_HIT_OUT)
		else $error("reserved read not zero");

	readback_write_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		REG_WR_EN_IN && byte_index(REG_ADDR_IN) >= 0 ##1
		REG_RD_EN_IN && !REG_WR_EN_IN && REG_ADDR_IN == $past(REG_ADDR_IN)
		|=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2))
		else $error("read back differs from write");

	left_den_rst_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		!past_valid_q |-> LEFT_COEFS_OUT.denominator_coef == 16'sh537e)
		else $error("left denominator default wrong");

	right_first_rst_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		!past_valid_q |-> RIGHT_COEFS_OUT.numerator_first_coef == 16'sh3955)
		else $error("right first numerator default wrong");

	right_second_rst_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		!past_valid_q |-> RIGHT_COEFS_OUT.numerator_second_coef == -16'sd3283)
		else $error("right second numerator default wrong");

	right_den_rst_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		!past_valid_q |-> RIGHT_COEFS_OUT.denominator_coef == 16'sh537e)
		else $error("right denominator default wrong");

	left_num_rst_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		!past_valid_q |-> LEFT_COEFS_OUT.numerator_first_coef == 16'sh3955 &&
		LEFT_COEFS_OUT.numerator_second_coef == 16'shf32d)
		else $error("left numerator defaults wrong");

	coef_join_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		REG_WR_EN_IN && REG_ADDR_IN == hpf_coef_pkg::RIGHT_HPF_DENOMINATOR_HIGH_OFS
		|=> RIGHT_COEFS_OUT.denominator_coef[15:8] == $past(REG_WDATA_IN) &&
		$stable(RIGHT_COEFS_OUT.denominator_coef[7:0]))
		else $error("upper byte not placed in coefficient");

	tail_nowrite_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		REG_WR_EN_IN && REG_ADDR_IN >= hpf_coef_pkg::PAGE_ONE_RESERVED_TAIL_OFS
		|=> $stable(LEFT_COEFS_OUT) && $stable(RIGHT_COEFS_OUT))
		else $error("tail write changed a coefficient");

	// ==========================================================
	// Write landing: each byte of registers 70 to 76 except 75 takes effect alone on the next edge
	// Checked against the filter outputs, so a swapped byte lane shows up here
	left_den_low_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		REG_WR_EN_IN && REG_ADDR_IN == hpf_coef_pkg::LEFT_HPF_DENOMINATOR_LOW_OFS
		|=> LEFT_COEFS_OUT.denominator_coef[7:0] == $past(REG_WDATA_IN))
		else $error("left denominator lower byte not written");

	right_first_high_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		REG_WR_EN_IN && REG_ADDR_IN == hpf_coef_pkg::RIGHT_HPF_NUM_FIRST_HIGH_OFS
		|=> RIGHT_COEFS_OUT.numerator_first_coef[15:8] == $past(REG_WDATA_IN))
		else $error("right first numerator upper byte not written");

	right_first_low_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		REG_WR_EN_IN && REG_ADDR_IN == hpf_coef_pkg::RIGHT_HPF_NUM_FIRST_LOW_OFS
		|=> RIGHT_COEFS_OUT.numerator_first_coef[7:0] == $past(REG_WDATA_IN))
		else $error("right first numerator lower byte not written");

	right_second_high_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		REG_WR_EN_IN && REG_ADDR_IN == hpf_coef_pkg::RIGHT_HPF_NUM_SECOND_HIGH_OFS
		|=> RIGHT_COEFS_OUT.numerator_second_coef[15:8] == $past(REG_WDATA_IN))
		else $error("right second numerator upper byte not written");

	right_second_low_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		REG_WR_EN_IN && REG_ADDR_IN == hpf_coef_pkg::RIGHT_HPF_NUM_SECOND_LOW_OFS
		|=> RIGHT_COEFS_OUT.numerator_second_coef[7:0] == $past(REG_WDATA_IN))
		else $error("right second numerator lower byte not written");

	right_den_low_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		REG_WR_EN_IN && REG_ADDR_IN == hpf_coef_pkg::RIGHT_HPF_DENOMINATOR_LOW_OFS
		|=> RIGHT_COEFS_OUT.denominator_coef[7:0] == $past(REG_WDATA_IN))
		else $error("right denominator lower byte not written");

	// ==========================================================
	// Read side and addresses that belong to other blocks
	read_map_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		REG_RD_EN_IN && byte_index(REG_ADDR_IN) >= 0 |=> REG_HIT_OUT &&
		REG_RDATA_OUT == $past(pick_byte(LEFT_COEFS_OUT, RIGHT_COEFS_OUT, REG_ADDR_IN)))
		else $error("read byte differs from coefficient output");

	hit_idle_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		!REG_RD_EN_IN |=> !REG_HIT_OUT)
		else $error("hit raised without a read");

	rdata_hold_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		!REG_RD_EN_IN |=> $stable(REG_RDATA_OUT))
		else $error("read data moved without a read");

	foreign_read_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		REG_RD_EN_IN && REG_ADDR_IN < hpf_coef_pkg::LEFT_NUM_FIRST_HIGH_OFS
		|=> REG_RDATA_OUT == hpf_coef_pkg::RESERVED_READ_VALUE && !REG_HIT_OUT)
		else $error("foreign read not zero or hit");

	foreign_nowrite_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		REG_WR_EN_IN && REG_ADDR_IN < hpf_coef_pkg::LEFT_NUM_FIRST_HIGH_OFS
		|=> $stable(LEFT_COEFS_OUT) && $stable(RIGHT_COEFS_OUT))
		else $error("foreign write changed a coefficient");

endmodule // adc_highpass_coef_bank

// ===== sim/host_model.sv
// Purpose: Host side of the coefficient bank, issuing byte strobes
// Assumes: Strobes launched and released at the falling edge
// Notes: Released address and data lines carry the inverse of the last value
`timescale 1ns/1ps
module host_model
(
	// Clock
	input wire logic clk_in,
	// Strobes and request lines
	output logic wr_en_out,
	output logic rd_en_out,
	output logic [6:0] addr_out,
	output logic [7:0] wdata_out,
	// Answer
	input wire logic [7:0] rdata_in,
	input wire logic hit_in
);
	// ==========================================================
	// Idle bus
	initial
	begin
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		addr_out = 7'h00;
		wdata_out = 8'h00;
	end

	// One-cycle write; the reserved tail is never written
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		if (a < hpf_coef_pkg::PAGE_ONE_RESERVED_TAIL_OFS)
		begin
			@(negedge clk_in);
			wr_en_out = 1'b1;
			addr_out = a;
			wdata_out = d;
			@(negedge clk_in);
			wr_en_out = 1'b0;
			addr_out = ~a;
			wdata_out = ~d;
		end
	endtask

	// One-cycle read; answer is taken where it has settled
	task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic h);
		@(negedge clk_in);
		rd_en_out = 1'b1;
		addr_out = a;
		@(negedge clk_in);
		rd_en_out = 1'b0;
		addr_out = ~a;
		d = rdata_in;
		h = hit_in;
	endtask

	// Write, then read the same byte on the very next edge
	task automatic wr_rd(input logic [6:0] a, input logic [7:0] d, output logic [7:0] q,
		output logic h);
		@(negedge clk_in);
		wr_en_out = 1'b1;
		addr_out = a;
		wdata_out = d;
		@(negedge clk_in);
		wr_en_out = 1'b0;
		rd_en_out = 1'b1;
		wdata_out = ~d;
		@(negedge clk_in);
		rd_en_out = 1'b0;
		addr_out = ~a;
		q = rdata_in;
		h = hit_in;
	endtask
endmodule // host_model

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the high-pass coefficient bank
// Assumes: Host model drives the strobes
// Notes: Expected bytes live in a shadow array
`timescale 1ns/1ps
module tb_top;
	// ==========================================================
	// Signals
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic wr_en;
	logic rd_en;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic hit;
	hpf_coef_pkg::hpf_coefs_t left_coefs;
	hpf_coef_pkg::hpf_coefs_t right_coefs;
	logic [7:0] shadow [65:76];
	logic [7:0] lfsr = 8'h1e;
	int n_fail = 0;
	int comparisons = 0;

	// 20 MHz clock
	always #25 core_clk = ~core_clk;

	adc_highpass_coef_bank uut
	(
		.CORE_CLK_IN(core_clk),
		.RESETN_IN(resetn),
		.REG_WR_EN_IN(wr_en),
		.REG_RD_EN_IN(rd_en),
		.REG_ADDR_IN(addr),
		.REG_WDATA_IN(wdata),
		.REG_RDATA_OUT(rdata),
		.REG_HIT_OUT(hit),
		.LEFT_COEFS_OUT(left_coefs),
		.RIGHT_COEFS_OUT(right_coefs)
	);

	host_model host
	(
		.clk_in(core_clk),
		.wr_en_out(wr_en),
		.rd_en_out(rd_en),
		.addr_out(addr),
		.wdata_out(wdata),
		.rdata_in(rdata),
		.hit_in(hit)
	);

	// ==========================================================
	// Helpers
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// Defaults repeat every six registers, one set per channel
	function automatic logic [7:0] dflt(input int a);
		case ((a - 65) % 6)
			0: return hpf_coef_pkg::NUM_FIRST_HIGH_RST;
			1: return hpf_coef_pkg::NUM_FIRST_LOW_RST;
			2: return hpf_coef_pkg::NUM_SECOND_HIGH_RST;
			3: return hpf_coef_pkg::NUM_SECOND_LOW_RST;
			4: return hpf_coef_pkg::DEN_HIGH_RST;
			default: return hpf_coef_pkg::DEN_LOW_RST;
		endcase
	endfunction

	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		if (n_fail == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Sixteen cycles low, then the shadow returns to defaults
	task automatic do_reset;
		@(negedge core_clk);
		resetn = 1'b0;
		repeat (16) @(negedge core_clk);
		resetn = 1'b1;
		for (int a = 65; a < 77; a++)
			shadow[a] = dflt(a);
	endtask

	// Read every byte back, then compare both channel words
	task automatic check_all(input bit fresh);
		logic [7:0] d;
		logic h;
		for (int a = 65; a < 77; a++)
		begin
			host.rd(7'(a), d, h);
			chk(48'(d), 48'(shadow[a]));
			chk(48'(h), 48'h1);
			if (fresh)
				chk(48'(d), 48'(dflt(a)));
		end
		chk(left_coefs, {shadow[65], shadow[66], shadow[67], shadow[68], shadow[69], shadow[70]});
		chk(right_coefs, {shadow[71], shadow[72], shadow[73], shadow[74], shadow[75], shadow[76]});
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		logic [6:0] a;
		logic [7:0] d;
		logic h;
		do_reset;
		check_all(1'b1);
		chk(48'(left_coefs.numerator_second_coef < 0), 48'h1);
		// Most negative word, bytes written lower first
		host.wr(hpf_coef_pkg::RIGHT_HPF_DENOMINATOR_LOW_OFS, 8'h00);
		host.wr(hpf_coef_pkg::RIGHT_HPF_DENOMINATOR_HIGH_OFS, 8'h80);
		shadow[75] = 8'h80;
		shadow[76] = 8'h00;
		chk(48'(right_coefs.denominator_coef == -32768), 48'h1);
		repeat (40)
		begin
			lfsr = lfsr_next(lfsr);
			a = 7'h41 + 7'(lfsr % 12);
			lfsr = lfsr_next(lfsr);
			host.wr(a, lfsr);
			shadow[a] = lfsr;
		end
		// Write then read back on the next edge
		repeat (8)
		begin
			lfsr = lfsr_next(lfsr);
			a = 7'h41 + 7'(lfsr % 12);
			lfsr = lfsr_next(lfsr);
			host.wr_rd(a, lfsr, d, h);
			shadow[a] = lfsr;
			chk(48'({d, h}), 48'({lfsr, 1'b1}));
		end
		// Other blocks' registers: writes leave the bank alone, reads give zero, no hit
		for (int r = 0; r < 65; r += 16)
		begin
			host.wr(7'(r), 8'hff);
			host.rd(7'(r), d, h);
			chk(48'({d, h}), 48'h000);
		end
		check_all(1'b0);
		// Reserved tail reads zero with the decode hit
		for (int r = 77; r < 128; r++)
		begin
			host.rd(7'(r), d, h);
			chk(48'({d, h}), 48'h001);
		end
		do_reset;
		check_all(1'b1);
		stop_test;
	end

	// Watchdog: a hang counts as a mismatch
	initial
	begin
		#5000000;
		n_fail++;
		stop_test;
	end
endmodule // tb_top
